/* File: rtl/counter_array_pkg.sv */
// Constants shared by the counter array and its compare/capture units.
// Assumes byte addresses on a 32-bit AHB-Lite register bus.
package counter_array_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_MODULE_MODE_BASE = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE_BASE = 8'h30;
  localparam logic [7:0] ADDR_STRIDE = 8'h04;

  // ==========================================================================
  // counter_control_register fields
  localparam int CONTROL_OVERFLOW_BIT = 7;
  localparam int CONTROL_RUN_BIT = 6;
  localparam int CONTROL_FLAG_WIDTH = 6;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ==========================================================================
  // counter_mode_register fields
  localparam int MODE_IDLE_STOP_BIT = 7;
  localparam int MODE_WATCHDOG_BIT = 6;
  localparam int MODE_SOURCE_HI_BIT = 2;
  localparam int MODE_SOURCE_LO_BIT = 1;
  localparam int MODE_OVERFLOW_IE_BIT = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // ==========================================================================
  // module_mode_register fields
  localparam int MM_WIDTH = 7;
  localparam int MM_COMPARATOR_BIT = 6;
  localparam int MM_RISING_BIT = 5;
  localparam int MM_FALLING_BIT = 4;
  localparam int MM_MATCH_BIT = 3;
  localparam int MM_TOGGLE_BIT = 2;
  localparam int MM_PWM_BIT = 1;
  localparam int MM_IRQ_ENABLE_BIT = 0;
  localparam logic [6:0] MM_RESET = 7'h00;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;

  // ==========================================================================
  // Count sources and timing
  localparam logic [1:0] SOURCE_DIV6 = 2'h0;
  localparam logic [1:0] SOURCE_DIV2 = 2'h1;
  localparam logic [1:0] SOURCE_TIMER0 = 2'h2;
  localparam logic [1:0] SOURCE_EXTERNAL = 2'h3;
  localparam logic [2:0] PRESCALE_LAST = 3'h5;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] LOW_BYTE_MAX = 8'hFF;
  localparam int WATCHDOG_MODULE = 4;

endpackage : counter_array_pkg

/* File: rtl/compare_capture_unit.sv */
// One compare/capture module: capture register, comparator, toggle and PWM.
// Assumes pin_level is already synchronised to hclk.
module compare_capture_unit (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Configuration and time base
  input wire logic [6:0] mode,
  input wire logic [15:0] count,
  input wire logic [15:0] next_count,
  input wire logic tick,
  // Pin
  input wire logic pin_level,
  output logic pin_out,
  output logic pin_oe,
  // Software access to the capture register
  input wire logic capture_write,
  input wire logic [15:0] capture_wdata,
  output logic [15:0] capture_value,
  // Events
  output logic module_event,
  output logic raw_match
);

  // ==========================================================================
  // Decode
  logic prev_level;
  wire cmp_en = mode[counter_array_pkg::MM_COMPARATOR_BIT];
  wire rise_en = mode[counter_array_pkg::MM_RISING_BIT];
  wire fall_en = mode[counter_array_pkg::MM_FALLING_BIT];
  wire mat_en = mode[counter_array_pkg::MM_MATCH_BIT];
  wire tog_en = mode[counter_array_pkg::MM_TOGGLE_BIT];
  wire pwm_en = mode[counter_array_pkg::MM_PWM_BIT];
  wire rise_seen = pin_level & ~prev_level;
  wire fall_seen = ~pin_level & prev_level;
  // Match is judged on the value the counter is about to take
  assign raw_match = tick & (next_count == capture_value);
  wire compare_match = raw_match & cmp_en;
  wire match_event = compare_match & mat_en;
  wire capture_event = (rise_seen & rise_en) | (fall_seen & fall_en);
  wire pwm_level = count[7:0] >= capture_value[7:0];
  wire pwm_reload = pwm_en & tick
    & (count[7:0] == counter_array_pkg::LOW_BYTE_MAX);
  assign module_event = capture_event | match_event;
  // Pin is released whenever no output function uses it
  assign pin_oe = tog_en | pwm_en;

  // ==========================================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_level <= 1'b0;
      capture_value <= counter_array_pkg::CAPTURE_RESET;
      pin_out <= 1'b0;
    end else begin
      prev_level <= pin_level;
      if (capture_write) begin
        capture_value <= capture_wdata;
      end else if (capture_event) begin
        capture_value <= count;
      end else if (pwm_reload) begin
        capture_value[7:0] <= capture_value[15:8];
      end
      if (pwm_en) begin
        pin_out <= pwm_level;
      end else if (compare_match & tog_en) begin
        pin_out <= ~pin_out;
      end
    end
  end

  // ==========================================================================
  // Checks
  property p_capture_loads;
    @(posedge hclk) disable iff (!hresetn)
    capture_event && !capture_write |=> capture_value == $past(count);
  endproperty
  a_capture_loads: assert property (p_capture_loads)
    else $error("capture register missed the counter value");

  property p_toggle_inverts;
    @(posedge hclk) disable iff (!hresetn)
    compare_match && tog_en && !pwm_en |=> pin_out != $past(pin_out);
  endproperty
  a_toggle_inverts: assert property (p_toggle_inverts)
    else $error("toggle output did not invert on match");

endmodule : compare_capture_unit

/* File: rtl/counter_array.sv */
// Programmable counter array: shared 16-bit counter, compare/capture units,
// AHB-Lite register slave. Assumes pins arrive asynchronous to hclk and
// that timer0_overflow and cpu_idle come from logic on hclk.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.

module counter_array #(
  parameter int NUM_MODULES = 5
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // System
  input wire logic timer0_overflow,
  input wire logic cpu_idle,
  output logic irq,
  output logic watchdog_reset,
  // Pins
  input wire logic external_count_input,
  input wire logic [NUM_MODULES-1:0] module_io_in,
  output logic [NUM_MODULES-1:0] module_io_out,
  output logic [NUM_MODULES-1:0] module_io_oe
);

  // ==========================================================================
  // Parameter check
  // Flags share the control byte with run and overflow bits
  generate
    if (NUM_MODULES <= counter_array_pkg::WATCHDOG_MODULE
        || NUM_MODULES > counter_array_pkg::CONTROL_FLAG_WIDTH) begin : g_bad
      $error("NUM_MODULES must be 5 or 6");
    end
  endgenerate

  // ==========================================================================
  // Bus slave: zero wait states, write data applied in the data phase
  logic data_sel;
  logic data_write;
  logic [7:0] data_addr;
  wire addr_phase = hsel & htrans[1] & hready;
  wire bus_write = data_sel & data_write;
  wire wr_control = bus_write & (data_addr == counter_array_pkg::ADDR_CONTROL);
  wire wr_mode = bus_write & (data_addr == counter_array_pkg::ADDR_MODE);
  wire wr_count = bus_write & (data_addr == counter_array_pkg::ADDR_COUNT);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_sel <= 1'b0;
      data_write <= 1'b0;
      data_addr <= 8'h00;
    end else begin
      data_sel <= addr_phase;
      if (addr_phase) begin
        data_write <= hwrite;
        data_addr <= haddr[7:0];
      end
    end
  end

  // ==========================================================================
  // Control and mode registers
  logic counter_run;
  logic counter_overflow_flag;
  logic [NUM_MODULES-1:0] module_event_flags;
  logic [7:0] mode_reg;
  logic [NUM_MODULES-1:0] module_events;
  logic [NUM_MODULES-1:0] module_irq_enable;
  wire idle_stop = mode_reg[counter_array_pkg::MODE_IDLE_STOP_BIT];
  wire watchdog_enable = mode_reg[counter_array_pkg::MODE_WATCHDOG_BIT];
  wire overflow_irq_enable = mode_reg[counter_array_pkg::MODE_OVERFLOW_IE_BIT];
  wire [1:0] count_source = {
    mode_reg[counter_array_pkg::MODE_SOURCE_HI_BIT],
    mode_reg[counter_array_pkg::MODE_SOURCE_LO_BIT]};
  wire overflow_event;
  // Hardware set wins over a software write in the same cycle
  wire next_overflow_flag = overflow_event
    | (wr_control ? hwdata[counter_array_pkg::CONTROL_OVERFLOW_BIT]
                  : counter_overflow_flag);
  wire [NUM_MODULES-1:0] next_module_flags = module_events
    | (wr_control ? hwdata[NUM_MODULES-1:0] : module_event_flags);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_run <= counter_array_pkg::CONTROL_RESET[6];
      counter_overflow_flag <= counter_array_pkg::CONTROL_RESET[7];
      module_event_flags <= '0;
      mode_reg <= counter_array_pkg::MODE_RESET;
    end else begin
      if (wr_control) begin
        counter_run <= hwdata[counter_array_pkg::CONTROL_RUN_BIT];
      end
      counter_overflow_flag <= next_overflow_flag;
      module_event_flags <= next_module_flags;
      if (wr_mode) begin
        mode_reg <= hwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Pin synchronisers
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic [NUM_MODULES-1:0] io_meta;
  logic [NUM_MODULES-1:0] io_sync;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
      io_meta <= '0;
      io_sync <= '0;
    end else begin
      ext_meta <= external_count_input;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
      io_meta <= module_io_in;
      io_sync <= io_meta;
    end
  end

  // Falling edge of the count pin, seen once per transition
  wire ext_event = ext_prev & ~ext_sync;

  // ==========================================================================
  // Prescaler and count source
  // One divider serves both rates: bit 0 toggles every cycle within 0..5
  logic [2:0] prescale;
  wire div6_pulse = prescale == counter_array_pkg::PRESCALE_LAST;
  wire div2_pulse = prescale[0];
  wire source_event =
    (count_source == counter_array_pkg::SOURCE_DIV6) ? div6_pulse :
    (count_source == counter_array_pkg::SOURCE_DIV2) ? div2_pulse :
    (count_source == counter_array_pkg::SOURCE_TIMER0) ? timer0_overflow :
    ext_event;
  wire running = counter_run & ~(idle_stop & cpu_idle);
  // A software load of the counter takes precedence over a step
  wire tick = running & source_event & ~wr_count;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale <= 3'h0;
    end else if (div6_pulse) begin
      prescale <= 3'h0;
    end else begin
      prescale <= prescale + 3'h1;
    end
  end

  // ==========================================================================
  // Shared counter
  logic [15:0] count;
  wire [15:0] next_count = count + 16'h0001;
  assign overflow_event = tick & (count == counter_array_pkg::COUNT_MAX);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 16'h0000;
    end else if (wr_count) begin
      count <= hwdata[15:0];
    end else if (tick) begin
      count <= next_count;
    end
  end

  // ==========================================================================
  // Compare/capture modules
  logic [6:0] module_mode [NUM_MODULES];
  logic [15:0] capture_value [NUM_MODULES];
  logic [NUM_MODULES-1:0] raw_match;
  logic [31:0] module_rdata [NUM_MODULES];

  generate
    for (genvar i = 0; i < NUM_MODULES; i++) begin : g_module
      localparam logic [7:0] MODE_ADDR = 8'(
        counter_array_pkg::ADDR_MODULE_MODE_BASE
        + i * counter_array_pkg::ADDR_STRIDE);
      localparam logic [7:0] CAP_ADDR = 8'(
        counter_array_pkg::ADDR_CAPTURE_BASE
        + i * counter_array_pkg::ADDR_STRIDE);
      wire mode_hit = data_addr == MODE_ADDR;
      wire cap_hit = data_addr == CAP_ADDR;

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          module_mode[i] <= counter_array_pkg::MM_RESET;
        end else if (bus_write & mode_hit) begin
          module_mode[i] <= hwdata[6:0];
        end
      end

      assign module_irq_enable[i] =
        module_mode[i][counter_array_pkg::MM_IRQ_ENABLE_BIT];
      assign module_rdata[i] =
        mode_hit ? {25'h0, module_mode[i]} :
        cap_hit ? {16'h0, capture_value[i]} : 32'h0;

      compare_capture_unit u_unit (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(module_mode[i]),
        .count(count),
        .next_count(next_count),
        .tick(tick),
        .pin_level(io_sync[i]),
        .pin_out(module_io_out[i]),
        .pin_oe(module_io_oe[i]),
        .capture_write(bus_write & cap_hit),
        .capture_wdata(hwdata[15:0]),
        .capture_value(capture_value[i]),
        .module_event(module_events[i]),
        .raw_match(raw_match[i])
      );
    end
  endgenerate

  // ==========================================================================
  // Watchdog and interrupt
  // Internal reset pulse only; the external reset pin is never driven
  wire watchdog_hit = watchdog_enable
    & raw_match[counter_array_pkg::WATCHDOG_MODULE];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= watchdog_hit;
    end
  end

  assign irq = (counter_overflow_flag & overflow_irq_enable)
    | |(module_event_flags & module_irq_enable);

  // ==========================================================================
  // Read data, taken from the data-phase address
  logic [31:0] module_rd_any;
  always_comb begin
    module_rd_any = 32'h0;
    for (int i = 0; i < NUM_MODULES; i++) begin
      module_rd_any = module_rd_any | module_rdata[i];
    end
  end

  wire [31:0] control_rdata = {24'h0, counter_overflow_flag, counter_run,
    counter_array_pkg::CONTROL_FLAG_WIDTH'(module_event_flags)};
  assign hrdata =
    (data_addr == counter_array_pkg::ADDR_CONTROL) ? control_rdata :
    (data_addr == counter_array_pkg::ADDR_MODE) ? {24'h0, mode_reg} :
    (data_addr == counter_array_pkg::ADDR_COUNT) ? {16'h0, count} :
    module_rd_any;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_div6_gap;
    !div6_pulse [*5] ##1 div6_pulse;
  endsequence

  property p_div6_period;
    div6_pulse |=> s_div6_gap;
  endproperty
  a_div6_period: assert property (p_div6_period)
    else $error("divide-by-six pulse spacing wrong");

  property p_overflow_sets;
    overflow_event |=> counter_overflow_flag && count == 16'h0000;
  endproperty
  a_overflow_sets: assert property (p_overflow_sets)
    else $error("overflow did not set the flag");

  property p_overflow_held;
    counter_overflow_flag && !wr_control |=> counter_overflow_flag;
  endproperty
  a_overflow_held: assert property (p_overflow_held)
    else $error("overflow flag cleared without software");

  property p_stopped;
    !counter_run && !wr_count |=> count == $past(count);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved while stopped");

  property p_idle_stop;
    idle_stop && cpu_idle |-> !tick;
  endproperty
  a_idle_stop: assert property (p_idle_stop)
    else $error("counter stepped during idle with idle stop");

  property p_step;
    tick |=> count == $past(count) + 16'h0001;
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not step by one");

  property p_module_irq;
    (module_event_flags & module_irq_enable) != '0 |-> irq;
  endproperty
  a_module_irq: assert property (p_module_irq)
    else $error("module flag did not raise the interrupt");

  // A pulse follows each hit; back-to-back hits may stretch it
  sequence s_watchdog_pulse;
    watchdog_reset ##1 (watchdog_reset == $past(watchdog_hit));
  endsequence

  property p_watchdog;
    watchdog_hit |=> s_watchdog_pulse;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog match gave no reset pulse");

  property p_flag_set_wins;
    module_events != '0
      |=> (module_event_flags & $past(module_events)) == $past(module_events);
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins)
    else $error("module event lost");

endmodule : counter_array

/* File: sim/pin_partner.sv */
// Model of the outside world on the port pins around the counter array.
// Assumes the bench sets requested levels just after rising edges of hclk.
module pin_partner #(
  parameter int N = 5
) (
  // Clock
  input wire logic hclk,
  // Levels the bench asks the outside world to drive
  input wire logic ext_req,
  input wire logic [N-1:0] pin_req,
  // Array side of the pins
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe,
  output logic external_count_input,
  output logic [N-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [N-1:0] drive;

  // ==========================================================================
  // Outside drivers
  // Levels move a clock after the request, on a rising edge of hclk, so they are edge-aligned
  // to the sampling flops inside the array rather than truly asynchronous.
  always_ff @(posedge hclk) begin
    external_count_input <= ext_req;
    drive <= pin_req;
  end

  // A pin the array drives carries its level; otherwise the outside owns it
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule : pin_partner

/* File: sim/counter_array_tb.sv */
// Self-checking bench for the counter array, driven over AHB-Lite.
// Assumes pin_partner stands for everything outside the port pins.
module counter_array_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic timer0_overflow, cpu_idle, watchdog_reset, ext_req, ext_pin;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [4:0] pin_req, io_in, io_out, io_oe;
  int miscompares, compares;
  localparam logic [7:0] CTL = counter_array_pkg::ADDR_CONTROL;
  localparam logic [7:0] MOD = counter_array_pkg::ADDR_MODE;
  localparam logic [7:0] CNT = counter_array_pkg::ADDR_COUNT;
  localparam logic [7:0] MM = counter_array_pkg::ADDR_MODULE_MODE_BASE;
  localparam logic [7:0] CAP = counter_array_pkg::ADDR_CAPTURE_BASE;
  localparam logic [1:0] DIV2 = counter_array_pkg::SOURCE_DIV2;

  counter_array dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .timer0_overflow(timer0_overflow),
    .cpu_idle(cpu_idle), .irq(irq), .watchdog_reset(watchdog_reset),
    .external_count_input(ext_pin), .module_io_in(io_in),
    .module_io_out(io_out), .module_io_oe(io_oe));

  pin_partner partner_u (.hclk(hclk), .ext_req(ext_req), .pin_req(pin_req),
    .pin_out(io_out), .pin_oe(io_oe), .external_count_input(ext_pin),
    .pin_level(io_in));

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] at(input logic [7:0] base, input int n);
    return base + 8'(n) * counter_array_pkg::ADDR_STRIDE;
  endfunction : at

  function automatic logic [31:0] cmode(input logic idle, input logic wd,
      input logic [1:0] src, input logic ie);
    return {24'h000000, idle, wd, 3'h0, src, ie};
  endfunction : cmode

  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Bus master holds each phase until hready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
      input string name);
    logic [31:0] q;
    xfer(1'b0, a, 32'h00000000, q);
    check(name, q, exp);
  endtask : rdc

  // Steps of the counter over exactly 12 clock cycles
  task automatic delta(output logic [31:0] d);
    logic [31:0] a, b;
    xfer(1'b0, CNT, 32'h00000000, a);
    repeat (9) @(posedge hclk);
    xfer(1'b0, CNT, 32'h00000000, b);
    d = {16'h0000, b[15:0] - a[15:0]};
  endtask : delta

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    check("hresp", 32'(hresp), 32'h0);
    check("pins released", 32'(io_oe), 32'h0);
    rdc(CTL, 32'h0, "control");
    rdc(MOD, 32'h0, "mode");
    rdc(CNT, 32'h0, "count");
    rdc(MM, 32'h0, "module mode");
    wr(8'hFC, 32'hFFFFFFFF);
    rdc(8'hFC, 32'h0, "unmapped");
  endtask : t_reset

  task automatic t_sources;
    logic [31:0] d, a, b;
    wr(MOD, cmode(0, 0, counter_array_pkg::SOURCE_DIV6, 0));
    wr(CTL, 32'h40);
    delta(d);
    check("div6 steps", d, 32'h2);
    wr(MOD, cmode(0, 0, DIV2, 0));
    delta(d);
    check("div2 steps", d, 32'h6);
    cpu_idle <= 1'b1;
    wr(MOD, cmode(1, 0, DIV2, 0));
    delta(d);
    check("idle stopped", d, 32'h0);
    wr(MOD, cmode(0, 0, DIV2, 0));
    delta(d);
    check("idle running", d, 32'h6);
    cpu_idle <= 1'b0;
    wr(CTL, 32'h0);
    delta(d);
    check("run cleared", d, 32'h0);
    wr(MOD, cmode(0, 0, counter_array_pkg::SOURCE_TIMER0, 0));
    wr(CTL, 32'h40);
    xfer(1'b0, CNT, 32'h0, a);
    repeat (4) begin
      @(posedge hclk) timer0_overflow <= 1'b1;
      @(posedge hclk) timer0_overflow <= 1'b0;
    end
    xfer(1'b0, CNT, 32'h0, b);
    check("timer0 steps", b - a, 32'h4);
    wr(MOD, cmode(0, 0, counter_array_pkg::SOURCE_EXTERNAL, 0));
    xfer(1'b0, CNT, 32'h0, a);
    repeat (3) begin
      @(posedge hclk) ext_req <= 1'b0;
      repeat (5) @(posedge hclk);
      ext_req <= 1'b1;
      repeat (5) @(posedge hclk);
    end
    xfer(1'b0, CNT, 32'h0, b);
    check("external steps", b - a, 32'h3);
    wr(CTL, 32'h0);
  endtask : t_sources

  task automatic t_overflow;
    wr(MOD, cmode(0, 0, DIV2, 0));
    wr(CNT, 32'hFFFE);
    wr(CTL, 32'h40);
    repeat (30) @(posedge hclk);
    rdc(CTL, 32'hC0, "overflow flag");
    check("irq masked", 32'(irq), 32'h0);
    wr(MOD, cmode(0, 0, DIV2, 1));
    @(posedge hclk);
    check("overflow irq", 32'(irq), 32'h1);
    wr(CTL, 32'h0);
    @(posedge hclk);
    check("irq cleared", 32'(irq), 32'h0);
    rdc(CTL, 32'h0, "flag cleared");
    wr(MOD, cmode(0, 0, DIV2, 0));
  endtask : t_overflow

  task automatic t_compare;
    wr(CNT, 32'h0100);
    wr(at(CAP, 1), 32'h0105);
    wr(at(CAP, 0), 32'h0108);
    wr(at(MM, 0), 32'h08);
    wr(at(MM, 1), 32'h4C);
    @(posedge hclk);
    check("toggle pin", 32'({io_oe, io_out}), 32'h040);
    wr(CTL, 32'h40);
    repeat (30) @(posedge hclk);
    rdc(CTL, 32'h42, "match flag");
    wr(CTL, 32'h02);
    check("toggled", 32'(io_out[1]), 32'h1);
    check("irq disabled", 32'(irq), 32'h0);
    wr(at(MM, 1), 32'h4D);
    @(posedge hclk);
    check("module irq", 32'(irq), 32'h1);
    wr(CTL, 32'h0);
    @(posedge hclk);
    check("flag cleared", 32'(irq), 32'h0);
    wr(at(MM, 1), 32'h0);
    wr(at(MM, 0), 32'h0);
  endtask : t_compare

  task automatic t_capture;
    wr(CNT, 32'h1234);
    wr(at(MM, 2), 32'h20);
    pin_req[2] <= 1'b1;
    repeat (6) @(posedge hclk);
    rdc(at(CAP, 2), 32'h1234, "rising capture");
    rdc(CTL, 32'h04, "capture flag");
    wr(CTL, 32'h0);
    wr(CNT, 32'h2222);
    pin_req[2] <= 1'b0;
    repeat (6) @(posedge hclk);
    rdc(at(CAP, 2), 32'h1234, "falling ignored");
    wr(at(MM, 2), 32'h31);
    pin_req[2] <= 1'b1;
    repeat (6) @(posedge hclk);
    rdc(at(CAP, 2), 32'h2222, "both edges");
    check("capture irq", 32'(irq), 32'h1);
    wr(CTL, 32'h0);
    wr(CNT, 32'h3333);
    pin_req[2] <= 1'b0;
    repeat (6) @(posedge hclk);
    rdc(at(CAP, 2), 32'h3333, "falling capture");
    rdc(CTL, 32'h04, "falling flag");
    wr(CTL, 32'h0);
    wr(at(MM, 2), 32'h0);
  endtask : t_capture

  task automatic t_pwm;
    wr(at(CAP, 3), 32'h8040);
    wr(CNT, 32'h0010);
    wr(at(MM, 3), 32'h02);
    repeat (3) @(posedge hclk);
    check("pwm low", 32'({io_oe[3], io_out[3]}), 32'h2);
    wr(CNT, 32'h0040);
    repeat (3) @(posedge hclk);
    check("pwm high", 32'({io_oe[3], io_out[3]}), 32'h3);
    wr(CNT, 32'h00FE);
    wr(CTL, 32'h40);
    repeat (12) @(posedge hclk);
    wr(CTL, 32'h0);
    repeat (3) @(posedge hclk);
    check("pwm after reload", 32'(io_out[3]), 32'h0);
    rdc(at(CAP, 3), 32'h8080, "pwm reload");
    wr(at(MM, 3), 32'h0);
  endtask : t_pwm

  task automatic t_watchdog;
    logic s;
    for (int w = 1; w >= 0; w--) begin
      wr(CNT, 32'h0);
      wr(at(CAP, 4), 32'h0003);
      wr(MOD, cmode(0, w[0], DIV2, 0));
      wr(CTL, 32'h40);
      s = 1'b0;
      repeat (20) @(posedge hclk) s |= watchdog_reset;
      wr(CTL, 32'h0);
      check("watchdog", 32'(s), 32'(w));
    end
  endtask : t_watchdog

  task automatic finish_test;
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Clock, sequence and watchdog
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    timer0_overflow = 1'b0;
    cpu_idle = 1'b0;
    ext_req = 1'b1;
    pin_req = 5'h00;
    miscompares = 0;
    compares = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_sources();
    t_overflow();
    t_compare();
    t_capture();
    t_pwm();
    t_watchdog();
    finish_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    finish_test();
  end
endmodule : counter_array_tb
